// ==== src/ucm_serial_slave.sv ====
// two-wire serial slave: pointer byte, auto-incrementing writes and reads
// assumes clock and data lines are already synchronous to i_clk
`timescale 1ns/1ps
module ucm_serial_slave
   import ucm_pkg::*;
#(
   parameter logic [6:0] DEV_ADDR = DEF_DEV_ADDR
)(
   input  wire logic i_clk,
   input  wire logic i_rst_n,
   input  wire logic i_scl,
   input  wire logic i_sda,
   output logic      o_sda_oe,
   ucm_reg_if.slave  bus
);
   ucm_state_t state_reg;
   logic [7:0] sh_reg;
   logic [7:0] ptr_reg;
   logic [3:0] cnt_reg;
   logic       rw_reg;
   logic       first_reg;
   logic       scl_q;
   logic       sda_q;
   logic       wr_reg;
   logic       rd_reg;
   logic       oe_reg;
   wire  scl_rise = i_scl & ~scl_q;
   wire  scl_fall = ~i_scl & scl_q;
   wire  start_c  = i_scl & scl_q & sda_q & ~i_sda;
   wire  stop_c   = i_scl & scl_q & ~sda_q & i_sda;
   wire  byte_in  = (cnt_reg == BITS_PER_BYTE);
   wire  addr_hit = (sh_reg[7:1] == DEV_ADDR);

   assign bus.addr   = ptr_reg;
   assign bus.wdata  = sh_reg;
   assign bus.wr_stb = wr_reg;
   assign bus.rd_stb = rd_reg;
   assign o_sda_oe   = oe_reg;

   // bit level protocol engine
   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         state_reg <= UCM_IDLE;
         sh_reg    <= RST_BYTE;
         ptr_reg   <= RST_BYTE;
         cnt_reg   <= '0;
         rw_reg    <= 1'b0;
         first_reg <= 1'b0;
         scl_q     <= 1'b1;
         sda_q     <= 1'b1;
         wr_reg    <= 1'b0;
         rd_reg    <= 1'b0;
         oe_reg    <= 1'b0;
      end
      else
      begin
         scl_q  <= i_scl;
         sda_q  <= i_sda;
         wr_reg <= 1'b0;
         rd_reg <= 1'b0;
         if (wr_reg || rd_reg)
            ptr_reg <= ptr_reg + 8'h01;
         if (start_c)
         begin
            state_reg <= UCM_ADDR;
            cnt_reg   <= '0;
            oe_reg    <= 1'b0;
         end
         else if (stop_c)
         begin
            state_reg <= UCM_IDLE;
            oe_reg    <= 1'b0;
         end
         else
         begin
            case (state_reg)
               UCM_ADDR, UCM_RX:
               begin
                  if (scl_rise)
                  begin
                     sh_reg  <= {sh_reg[6:0], i_sda};
                     cnt_reg <= cnt_reg + 4'h1;
                  end
                  else if (scl_fall && byte_in)
                  begin
                     if (state_reg == UCM_RX)
                     begin
                        oe_reg    <= 1'b1;
                        state_reg <= UCM_RXACK;
                        if (first_reg)
                           ptr_reg <= sh_reg;
                        else
                           wr_reg  <= 1'b1;
                     end
                     else if (addr_hit)
                     begin
                        oe_reg    <= 1'b1;
                        rw_reg    <= sh_reg[0];
                        state_reg <= UCM_AACK;
                     end
                     else
                        state_reg <= UCM_IDLE;
                  end
               end
               UCM_AACK, UCM_RXACK:
               begin
                  if (scl_fall)
                  begin
                     cnt_reg   <= '0;
                     first_reg <= (state_reg == UCM_AACK);
                     if (state_reg == UCM_AACK && rw_reg)
                     begin
                        sh_reg    <= bus.rdata;
                        rd_reg    <= 1'b1;
                        oe_reg    <= ~bus.rdata[7];
                        state_reg <= UCM_TX;
                     end
                     else
                     begin
                        oe_reg    <= 1'b0;
                        state_reg <= UCM_RX;
                     end
                  end
               end
               UCM_TX:
               begin
                  if (scl_fall)
                  begin
                     if (cnt_reg == LAST_BIT)
                     begin
                        oe_reg    <= 1'b0;
                        state_reg <= UCM_TXACK;
                     end
                     else
                     begin
                        cnt_reg <= cnt_reg + 4'h1;
                        sh_reg  <= {sh_reg[6:0], 1'b0};
                        oe_reg  <= ~sh_reg[6];
                     end
                  end
               end
               UCM_TXACK:
               begin
                  // a not-acknowledge ends the read burst
                  if (scl_rise && i_sda)
                     state_reg <= UCM_IDLE;
                  else if (scl_fall)
                  begin
                     cnt_reg   <= '0;
                     sh_reg    <= bus.rdata;
                     rd_reg    <= 1'b1;
                     oe_reg    <= ~bus.rdata[7];
                     state_reg <= UCM_TX;
                  end
               end
               default:
                  state_reg <= UCM_IDLE;
            endcase
         end
      end
   end
endmodule

// ==== src/ucm_pkg.sv ====
// constants shared by the charger interrupt flag block and its serial slave
// assumes one 50 MHz clock and an asynchronous active-low reset
package ucm_pkg;
   localparam logic [7:0] OFS_EVENT_EN   = 8'h07;
   localparam logic [7:0] OFS_FAULT_EN   = 8'h08;
   localparam logic [7:0] OFS_AUX_EN     = 8'h09;
   localparam logic [7:0] OFS_EVENT_FLG  = 8'h0A;
   localparam logic [7:0] OFS_FAULT_FLG  = 8'h0B;
   localparam logic [7:0] OFS_AUX_FLG    = 8'h0C;
   localparam logic [7:0] OFS_SETUP      = 8'h0D;
   localparam int         BIT_AUTOCLR    = 7;
   localparam int         BIT_PENDING    = 7;
   localparam int         BIT_STATE_EV   = 5;
   localparam int         BIT_TC_ATT     = 4;
   localparam int         BIT_LG_ATT     = 3;
   localparam int         BIT_TC_EV      = 2;
   localparam int         BIT_LG_EV      = 1;
   localparam int         BIT_MEAS       = 0;
   localparam int         BIT_CONN_ERR   = 4;
   localparam int         BIT_CONN_LIM   = 0;
   localparam logic [7:0] RST_BYTE       = 8'h00;
   localparam logic [7:0] EV_EN_MASK     = 8'hBF;
   localparam logic [7:0] FLT_EN_MASK    = 8'h7F;
   localparam logic [7:0] AUX_EN_MASK    = 8'h3F;
   localparam logic [7:0] CONN_PWR_BITS  = 8'h11;
   localparam logic [7:0] IRQ_SRC_MASK   = 8'h3F;
   localparam logic [3:0] BITS_PER_BYTE  = 4'h8;
   localparam logic [3:0] LAST_BIT       = 4'h7;
   localparam logic [6:0] DEF_DEV_ADDR   = 7'h38;
   typedef enum logic [2:0] {
      UCM_IDLE  = 3'b000,
      UCM_ADDR  = 3'b001,
      UCM_AACK  = 3'b011,
      UCM_RX    = 3'b010,
      UCM_RXACK = 3'b110,
      UCM_TX    = 3'b111,
      UCM_TXACK = 3'b101
   } ucm_state_t;
endpackage

// ==== src/ucm_reg_if.sv ====
// byte register access carrier between the serial slave and the flag block
// assumes both ends run on the same clock
`timescale 1ns/1ps
interface ucm_reg_if;
   logic [7:0] addr;
   logic [7:0] wdata;
   logic       wr_stb;
   logic       rd_stb;
   logic [7:0] rdata;
   modport slave (output addr, output wdata, output wr_stb,
                  output rd_stb, input rdata);
   modport regs (input addr, input wdata, input wr_stb,
                 input rd_stb, output rdata);
endinterface

// ==== src/ucm_irq_flags.sv ====
// interrupt enables, condition flags and interrupt output of the charger
// assumes condition inputs are synchronous; event inputs are 1-cycle pulses
`timescale 1ns/1ps
module ucm_irq_flags
   import ucm_pkg::*;
#(
   parameter logic [6:0] DEV_ADDR     = DEF_DEV_ADDR,
   parameter bit         HAS_CONN_PWR = 1'b1
)(
   input  wire logic       i_clk,
   input  wire logic       i_rst_n,
   input  wire logic       i_scl,
   input  wire logic       i_sda,
   output logic            o_sda,
   output logic            o_sda_oe,
   input  wire logic       i_meas_done,
   input  wire logic       i_typec_state_change,
   input  wire logic       i_typec_attached,
   input  wire logic       i_legacy_attached,
   input  wire logic [6:0] i_fault_cond,
   input  wire logic [5:0] i_aux_fault_cond,
   output logic            o_irq_n,
   output logic            o_setup_done
);
   ucm_reg_if  rif ();
   logic [7:0] ev_en_reg;
   logic [7:0] flt_en_reg;
   logic [7:0] aux_en_reg;
   logic [7:0] ev_flg_reg;
   logic [7:0] flt_flg_reg;
   logic [7:0] aux_flg_reg;
   logic       cfg_reg;
   logic       tc_prev_reg;
   logic       lg_prev_reg;
   logic       irq_n_reg;
   logic       sda_reg;
   logic [7:0] rd_snap_reg;

   // decode of a register pointer against one offset
   function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
      hit = (a == o);
   endfunction

   ucm_serial_slave #(.DEV_ADDR(DEV_ADDR)) u_slave (
      .i_clk    (i_clk),
      .i_rst_n  (i_rst_n),
      .i_scl    (i_scl),
      .i_sda    (i_sda),
      .o_sda_oe (o_sda_oe),
      .bus      (rif.slave)
   );

   // write and read-clear strobes per register
   wire wr_ev   = rif.wr_stb & hit(rif.addr, OFS_EVENT_EN);
   wire wr_flt  = rif.wr_stb & hit(rif.addr, OFS_FAULT_EN);
   wire wr_aux  = rif.wr_stb & hit(rif.addr, OFS_AUX_EN);
   wire wr_cfg  = rif.wr_stb & hit(rif.addr, OFS_SETUP);
   wire rd_ev   = rif.rd_stb & hit(rif.addr, OFS_EVENT_FLG);
   wire rd_flt  = rif.rd_stb & hit(rif.addr, OFS_FAULT_FLG);
   wire rd_aux  = rif.rd_stb & hit(rif.addr, OFS_AUX_FLG);
   wire autoclr = ev_en_reg[BIT_AUTOCLR];

   // enable bits that exist on this variant
   wire [7:0] conn_keep = HAS_CONN_PWR ? 8'hFF : ~CONN_PWR_BITS;
   wire [7:0] aux_en_w  = AUX_EN_MASK & conn_keep;
   wire [7:0] aux_cond  = {2'b00, i_aux_fault_cond} & conn_keep;

   // attach edges in either direction
   wire tc_edge = i_typec_attached ^ tc_prev_reg;
   wire lg_edge = i_legacy_attached ^ lg_prev_reg;

   // live conditions: level ones clear by read or auto-clear once gone
   wire [7:0] ev_level = {3'b000, i_typec_attached, i_legacy_attached,
                          3'b000};
   wire [7:0] ev_pulse = {2'b00, i_typec_state_change, 2'b00,
                          tc_edge, lg_edge, i_meas_done};
   // a read clears only the bits that went out in the byte, so an event
   // landing between the byte load and the clear is not lost
   wire [7:0] lvl_bits = {3'b000, 2'b11, 3'b000};
   wire [7:0] ev_clr   = ({8{rd_ev}} & rd_snap_reg)
                       | ({8{autoclr}} & lvl_bits);
   wire [7:0] ev_next;
   assign ev_next[6:0] = ev_level[6:0] | ev_pulse[6:0]
                       | (ev_flg_reg[6:0] & ~ev_clr[6:0]);
   assign ev_next[7]   = ~cfg_reg;

   wire [7:0] flt_next = {1'b0, i_fault_cond}
                       | (flt_flg_reg & ~(({8{rd_flt}} & rd_snap_reg)
                       | {8{autoclr}}));
   wire [7:0] aux_next = aux_cond
                       | (aux_flg_reg & ~(({8{rd_aux}} & rd_snap_reg)
                       | {8{autoclr}}));

   // gated sources into the single interrupt
   wire irq_any = |(ev_flg_reg & ev_en_reg & IRQ_SRC_MASK)
                | |(flt_flg_reg & flt_en_reg)
                | |(aux_flg_reg & aux_en_reg);

   // read data for the pointer, unmapped reads return zero
   assign rif.rdata = hit(rif.addr, OFS_EVENT_EN)  ? ev_en_reg   :
                      hit(rif.addr, OFS_FAULT_EN)  ? flt_en_reg  :
                      hit(rif.addr, OFS_AUX_EN)    ? aux_en_reg  :
                      hit(rif.addr, OFS_EVENT_FLG) ? ev_flg_reg  :
                      hit(rif.addr, OFS_FAULT_FLG) ? flt_flg_reg :
                      hit(rif.addr, OFS_AUX_FLG)   ? aux_flg_reg :
                      hit(rif.addr, OFS_SETUP)     ? {7'h00, cfg_reg} :
                      RST_BYTE;

   // enable registers and configuration-complete bit
   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         ev_en_reg  <= RST_BYTE;
         flt_en_reg <= RST_BYTE;
         aux_en_reg <= RST_BYTE;
         cfg_reg    <= 1'b0;
      end
      else
      begin
         if (wr_ev)
            ev_en_reg  <= rif.wdata & EV_EN_MASK;
         if (wr_flt)
            flt_en_reg <= rif.wdata & FLT_EN_MASK;
         if (wr_aux)
            aux_en_reg <= rif.wdata & aux_en_w;
         if (wr_cfg && rif.wdata[0])
            cfg_reg    <= 1'b1;
      end
   end

   // flag registers, a new event wins over a clearing read
   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         ev_flg_reg  <= RST_BYTE;
         flt_flg_reg <= RST_BYTE;
         aux_flg_reg <= RST_BYTE;
         tc_prev_reg <= 1'b0;
         lg_prev_reg <= 1'b0;
         rd_snap_reg <= RST_BYTE;
      end
      else
      begin
         rd_snap_reg <= rif.rdata; // byte the slave loads at this edge
         ev_flg_reg  <= ev_next;
         flt_flg_reg <= flt_next;
         aux_flg_reg <= aux_next;
         tc_prev_reg <= i_typec_attached;
         lg_prev_reg <= i_legacy_attached;
      end
   end

   // registered outputs
   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         irq_n_reg <= 1'b1;
         sda_reg   <= 1'b0;
      end
      else
      begin
         irq_n_reg <= ~irq_any;
         sda_reg   <= 1'b0;
      end
   end

   assign o_irq_n      = irq_n_reg;
   assign o_sda        = sda_reg;
   assign o_setup_done = cfg_reg;
endmodule

// ==== verif/ucm_irq_monitor.sv ====
// port checker of the charger interrupt flag block
// assumes it is bound to ucm_irq_flags and sees only its ports
`timescale 1ns/1ps
module ucm_irq_monitor (
   input wire logic       i_clk,
   input wire logic       i_rst_n,
   input wire logic       i_scl,
   input wire logic       i_sda,
   input wire logic       o_sda,
   input wire logic       o_sda_oe,
   input wire logic       i_meas_done,
   input wire logic       i_typec_state_change,
   input wire logic       i_typec_attached,
   input wire logic       i_legacy_attached,
   input wire logic [6:0] i_fault_cond,
   input wire logic [5:0] i_aux_fault_cond,
   input wire logic       o_irq_n,
   input wire logic       o_setup_done
);
   logic [17:0] prev_reg;
   logic [2:0]  quiet_reg;
   logic        seen_reg;
   // pin activity, quiet-cycle count and whether any source ever fired
   wire  [17:0] now_w = {i_scl, i_meas_done, i_typec_state_change,
      i_typec_attached, i_legacy_attached, i_fault_cond, i_aux_fault_cond};
   wire         act_w = (now_w != prev_reg) || i_meas_done;
   wire  [2:0]  quiet_next = act_w ? 3'h0
      : quiet_reg + {2'b00, quiet_reg != 3'h7};
   wire         seen_next = seen_reg | (|now_w[16:0]);
   // history registers for the checks below
   always_ff @(posedge i_clk or negedge i_rst_n)
      if (!i_rst_n)
         {prev_reg, quiet_reg, seen_reg} <= 22'h0;
      else
         {prev_reg, quiet_reg, seen_reg} <= {now_w, quiet_next, seen_next};
   default clocking dcb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);
   property p_rst_idle;
      !$past(i_rst_n) |-> o_irq_n && !o_setup_done;
   endproperty
   a_rst_idle: assert property (p_rst_idle) else $error("not idle");
   property p_no_src; !seen_reg |-> o_irq_n; endproperty
   a_no_src: assert property (p_no_src) else $error("irq, no source");
   property p_quiet; quiet_reg == 3'h7 |-> $stable(o_irq_n); endproperty
   a_quiet: assert property (p_quiet) else $error("irq moved idle");
   property p_setup_hold; o_setup_done |=> o_setup_done; endproperty
   a_setup_hold: assert property (p_setup_hold) else $error("setup");
   property p_setup_rise;
      $rose(o_setup_done) |-> quiet_reg != 3'h7;
   endproperty
   a_setup_rise: assert property (p_setup_rise) else $error("setup");
   property p_sda_zero; o_sda == 1'b0; endproperty
   a_sda_zero: assert property (p_sda_zero) else $error("sda drive");
   property p_oe_hold; i_scl && $past(i_scl) |-> $stable(o_sda_oe); endproperty
   a_oe_hold: assert property (p_oe_hold) else $error("oe moved");
   property p_oe_low; $changed(o_sda_oe) |-> !$past(i_scl); endproperty
   a_oe_low: assert property (p_oe_low) else $error("oe edge");
endmodule
bind ucm_irq_flags ucm_irq_monitor u_mon (.i_clk(i_clk), .i_rst_n(i_rst_n),
   .i_scl(i_scl), .i_sda(i_sda), .o_sda(o_sda), .o_sda_oe(o_sda_oe),
   .i_meas_done(i_meas_done), .i_typec_state_change(i_typec_state_change),
   .i_typec_attached(i_typec_attached),
   .i_legacy_attached(i_legacy_attached), .i_fault_cond(i_fault_cond),
   .i_aux_fault_cond(i_aux_fault_cond), .o_irq_n(o_irq_n),
   .o_setup_done(o_setup_done));

// ==== verif/ucm_host_model.sv ====
// host side of the two-wire register bus: byte writes and byte reads
// assumes the bench resolves the open-drain data line with a pull-up
`timescale 1ns/1ps
module ucm_host_model
   import ucm_pkg::*;
(
   input  wire logic i_clk,
   input  wire logic i_sda,
   output logic      o_scl,
   output logic      o_sda_oe,
   output logic      o_rd_valid,
   output logic [7:0] o_rd_data
);
   int hp = 3; // half bit time in clocks, raised for a slow host
   // bus released at time zero
   initial
      {o_scl, o_sda_oe, o_rd_valid, o_rd_data} = 11'h400;
   task automatic tick(input int n);
      repeat (n) @(negedge i_clk);
   endtask
   // drive while the clock is low, sample late in the high phase
   task automatic bit_io(input logic b, output logic s);
      o_scl = 1'b0;
      tick(1);
      o_sda_oe = ~b;
      tick(hp);
      o_scl = 1'b1;
      tick(hp);
      s = i_sda;
   endtask
   // v = 0 gives a start, v = 1 a stop
   task automatic cnd(input logic v);
      o_scl = 1'b0;
      tick(hp);
      o_sda_oe = v;
      tick(hp);
      o_scl = 1'b1;
      tick(hp);
      o_sda_oe = ~v;
      tick(hp);
   endtask
   // eight bits msb first, then the acknowledge bit
   task automatic xfer(input logic [7:0] d, input logic k,
                       output logic [7:0] q);
      logic s;
      for (int i = 7; i >= 0; i--)
      begin
         bit_io(d[i], s);
         q[i] = s;
      end
      bit_io(k, s);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] q;
      cnd(1'b0);
      xfer({DEF_DEV_ADDR, 1'b0}, 1'b1, q);
      xfer(a, 1'b1, q);
      xfer(d, 1'b1, q);
      cnd(1'b1);
   endtask
   // pointer write, repeated start, one byte read with a final nack
   task automatic rd(input logic [7:0] a);
      logic [7:0] q;
      cnd(1'b0);
      xfer({DEF_DEV_ADDR, 1'b0}, 1'b1, q);
      xfer(a, 1'b1, q);
      cnd(1'b0);
      xfer({DEF_DEV_ADDR, 1'b1}, 1'b1, q);
      xfer(8'hFF, 1'b1, q);
      cnd(1'b1);
      o_rd_data = q;
      o_rd_valid = 1'b1;
      tick(1);
      o_rd_valid = 1'b0;
   endtask
endmodule

// ==== verif/tb.sv ====
// self-checking bench of the charger interrupt flag block
// assumes the host model and the bound checker are compiled first
`timescale 1ns/1ps
module tb;
   import ucm_pkg::*;
   logic        i_clk = 1'b0;
   logic        i_rst_n = 1'b0;
   logic        meas, stc, tca, lga, smp;
   logic [12:0] cond, en, nb;
   logic [31:0] rnd;
   logic [9:0]  exp_q[$];
   int          err_total, n_tests;
   wire         scl, h_oe, d_oe, d_sda, irq_n, done, rd_v;
   wire  [7:0]  rd_d;
   wire         sda = ~(h_oe | d_oe); // pull-up on the data line
   always #10 i_clk = ~i_clk;
   ucm_irq_flags dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_scl(scl),
      .i_sda(sda), .o_sda(d_sda), .o_sda_oe(d_oe), .i_meas_done(meas),
      .i_typec_state_change(stc), .i_typec_attached(tca),
      .i_legacy_attached(lga), .i_fault_cond(cond[6:0]),
      .i_aux_fault_cond(cond[12:7]), .o_irq_n(irq_n), .o_setup_done(done));
   ucm_host_model host (.i_clk(i_clk), .i_sda(sda), .o_scl(scl),
      .o_sda_oe(h_oe), .o_rd_valid(rd_v), .o_rd_data(rd_d));
   task automatic chk(input logic [9:0] seen, input logic [9:0] want);
      n_tests++;
      if (seen !== want)
      begin
         err_total++;
         $display("[FAIL] %0t seen %h want %h", $time, seen, want);
      end
   endtask
   task automatic conclude;
      if (err_total == 0 && n_tests > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      exp_q.push_back({2'b00, e});
      host.rd(a);
   endtask
   // note the expected pins, then strobe the watcher
   task automatic pin(input logic s, input logic q);
      repeat (4) @(negedge i_clk);
      exp_q.push_back({2'b01, 6'h00, s, q});
      smp = 1'b1;
      @(negedge i_clk);
      smp = 1'b0;
   endtask
   // watcher: each result against the oldest note
   always @(posedge i_clk)
   begin
      if (rd_v)
         chk({2'b00, rd_d}, exp_q.pop_front());
      if (smp)
         chk({2'b01, 6'h00, done, irq_n}, exp_q.pop_front());
   end
   // hang guard
   initial
   begin
      repeat (60000) @(posedge i_clk);
      err_total++;
      conclude();
   end
   initial
   begin
      {meas, stc, tca, lga, smp} = 5'h00;
      cond = 13'h0000;
      rnd = $urandom(32'h2CE0DE39);
      repeat (6) @(negedge i_clk);
      i_rst_n = 1'b1;
      repeat (2) @(negedge i_clk);
      pin(1'b0, 1'b1);
      rd(OFS_FAULT_EN, 8'h00);
      rd(OFS_AUX_EN, 8'h00);
      rd(OFS_EVENT_EN, 8'h00);
      rd(OFS_EVENT_FLG, 8'h80);
      rnd = $urandom();
      host.wr(OFS_FAULT_EN, rnd[7:0]);
      host.wr(OFS_AUX_EN, rnd[15:8]);
      rd(OFS_FAULT_EN, rnd[7:0] & FLT_EN_MASK);
      rd(OFS_AUX_EN, rnd[15:8] & AUX_EN_MASK);
      // every fault source alone, a disabled neighbour raised first
      for (int j = 0; j < 13; j++)
      begin
         en = 13'h0001 << j;
         nb = 13'h0001 << ((j + 1) % 13);
         host.wr(OFS_FAULT_EN, {1'b0, en[6:0]});
         host.wr(OFS_AUX_EN, {2'b00, en[12:7]});
         cond = nb;
         pin(1'b0, 1'b1);
         cond = nb | en;
         pin(1'b0, 1'b0);
         cond = 13'h0000;
         rd(OFS_FAULT_FLG, {1'b0, en[6:0] | nb[6:0]});
         rd(OFS_AUX_FLG, {2'b00, en[12:7] | nb[12:7]});
         pin(1'b0, 1'b1);
      end
      // operating flags with a slow host
      host.hp = 5;
      host.wr(OFS_SETUP, 8'h01);
      host.wr(OFS_EVENT_EN, 8'h3F);
      pin(1'b1, 1'b1);
      {meas, stc, tca, lga} = 4'hF;
      @(negedge i_clk);
      {meas, stc} = 2'b00;
      pin(1'b1, 1'b0);
      rd(OFS_EVENT_FLG, 8'h3F);
      rd(OFS_EVENT_FLG, 8'h18);
      host.wr(OFS_EVENT_EN, 8'h80);
      pin(1'b1, 1'b1);
      {stc, tca, lga} = 3'b100;
      @(negedge i_clk);
      stc = 1'b0;
      rd(OFS_EVENT_FLG, 8'h26);
      host.wr(OFS_EVENT_EN, 8'h10);
      tca = 1'b1;
      pin(1'b1, 1'b0);
      tca = 1'b0;
      rd(OFS_EVENT_FLG, 8'h14);
      host.wr(OFS_EVENT_EN, 8'h02);
      lga = 1'b1;
      pin(1'b1, 1'b0);
      host.wr(OFS_EVENT_FLG, 8'hFF);
      rd(OFS_EVENT_FLG, 8'h0A);
      pin(1'b1, 1'b1);
      rd(8'h20, 8'h00);
      rd(OFS_EVENT_EN, 8'h02);
      // reset in mid-run with a device still attached
      i_rst_n = 1'b0;
      repeat (2) @(negedge i_clk);
      i_rst_n = 1'b1;
      repeat (2) @(negedge i_clk);
      pin(1'b0, 1'b1);
      rd(OFS_EVENT_EN, 8'h00);
      rd(OFS_EVENT_FLG, 8'h8A);
      repeat (4) @(negedge i_clk);
      conclude();
   end
endmodule
